// file: src/fft_frame_ctrl.sv
// Purpose: frame control, error checks and block float scaling of a fft
// Assumes: source, sink and apb all on pclk; sink_error from same domain
// Notes: the pass engine is a twiddle-free radix-2 stand-in for the core
// Function
// [R1] length input read only on start sample; code zero means maximum length
// [R2] upstream always drives length input, fixed builds drive chosen length
// [R3] inverse input sampled on start sample; high selects inverse transform
// [R4] frame length output travels aligned with that frame's output samples
// [R5] valid without a start marker reports error code 01
// [R6] N samples accepted without end marker on last reports code 10
// [R7] end marker before N samples accepted reports code 11
// [R8] after any framing error the controller must reset the device
// [R9] inputs are plain fixed point; input exponent taken as zero
// [R10] scaling allows for bit growth per pass when choosing shifts
// [R11] shifts of all passes summed into one block exponent
// [R12] block maximum found after each pass and whole block rescaled
// [R13] data shifted right before next pass when a carry is possible
// [R14] shift follows growth difference to previous pass maximum
// [R15] one exponent register holds the shared exponent of the block
// [R16] true magnitude equals output times two to minus exponent
// [R17] scaling shift applied before rounding of pass results
// [R18] every pass runs on one shared engine, reading and writing memory
// [R19] downstream rescales each output block by its final exponent
// [R20] output error is OR of upstream error and internal errors
// [R21] block exponent output is a six-bit signed value
// [R22] sample accepted only when valid and ready are both high
// [R23] exponent cleared at the start of each frame
// [R24] sample counter restarts at start marker and compares with N
`timescale 1ns/100ps
module fft_frame_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sample stream in
  input wire logic sink_valid,
  input wire logic sink_sop,
  input wire logic sink_eop,
  input wire logic [1:0] sink_error,
  input wire fft_frame_pkg::sample_type sink_data,
  input wire logic [3:0] fftpts_in,
  input wire logic inverse,
  output logic sink_ready,
  // sample stream out
  input wire logic source_ready,
  output logic source_valid,
  output logic source_sop,
  output logic source_eop,
  output logic [1:0] source_error,
  output logic [5:0] source_exp,
  output fft_frame_pkg::sample_type source_data,
  output logic [3:0] fftpts_out
);
  fft_frame_pkg::frame_state_type state, next_state;
  fft_frame_pkg::sample_type mem [16];
  fft_frame_pkg::sample_type next_mem [16];
  logic [4:0] cnt, next_cnt;
  logic [2:0] n_log, next_n_log;
  logic inv, next_inv;
  logic [1:0] err, next_err;
  logic [2:0] pass, next_pass;
  logic [2:0] bfly, next_bfly;
  logic [15:0] mag_or, next_mag_or;
  logic [15:0] prev_or, next_prev_or;
  // [R21] signed six-bit block exponent
  logic signed [5:0] exp_acc, next_exp_acc;
  logic [4:0] out_idx, next_out_idx;
  logic [15:0] frames, next_frames;
  logic [31:0] ctrl, next_ctrl;
  logic next_sink_ready, next_src_valid, next_src_sop, next_src_eop;
  logic [1:0] next_src_error;
  logic [5:0] next_src_exp;
  fft_frame_pkg::sample_type next_src_data;
  logic [3:0] next_pts_out;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  // engine wiring
  logic [4:0] n_pts;
  logic [3:0] lo, hi;
  logic [3:0] head;
  logic rsh;
  logic [3:0] lsh;
  logic signed [5:0] exp_step;
  logic signed [16:0] w_sum_re, w_sum_im, w_dif_re, w_dif_im;
  fft_frame_pkg::sample_type res_lo, res_hi;
  logic take;

  // leading redundant sign bits of an or of magnitudes
  function automatic logic [3:0] headroom(input logic [15:0] m);
    logic [3:0] h;
    h = 4'hF;
    for (int b = 0; b < 15; b++)
      if (m[b])
        h = 4'(14 - b);
    return h;
  endfunction : headroom

  // magnitude bits of a sample with the sign folded away
  function automatic logic [15:0] mag(input fft_frame_pkg::sample_type s);
    return (s.re ^ {16{s.re[15]}}) | (s.im ^ {16{s.im[15]}});
  endfunction : mag

  // [R22] accept handshake
  assign take = sink_valid & sink_ready;
  assign n_pts = 5'(1) << n_log;

  // [R18] shared butterfly: pair indices for this pass
  always_comb
  begin
    lo = 4'(((4'(bfly) >> pass) << (pass + 3'h1)) |
         (4'(bfly) & ((4'h1 << pass) - 4'h1)));
    hi = lo | (4'h1 << pass);
    w_sum_re = 17'(mem[lo].re) + 17'(mem[hi].re);
    w_sum_im = 17'(mem[lo].im) + 17'(mem[hi].im);
    w_dif_re = 17'(mem[lo].re) - 17'(mem[hi].re);
    w_dif_im = 17'(mem[lo].im) - 17'(mem[hi].im);
  end

  // [R14] shift plan from the growth seen on the previous pass
  always_comb
  begin
    head = headroom(prev_or);
    rsh = 1'b0;
    lsh = 4'h0;
    exp_step = 6'sh00;
    // [R10] one bit of growth per pass is allowed for
    if (!ctrl[fft_frame_pkg::CTRL_SCALE_BIT] || head == 4'h0)
    begin
      // [R13] scaling off or carry possible, shift right
      rsh = 1'b1;
      exp_step = -6'sh01;
    end
    else if (prev_or != 16'h0000 && head > 4'h1)
    begin
      // [R12] spare headroom is used to regain precision
      lsh = head - 4'h1;
      exp_step = 6'(lsh);
    end
  end

  // [R17] four scalers share one plan, shift happens before rounding
  bfp_scaler u_sum_re (.wide_in(w_sum_re), .shift_right(rsh),
    .shift_left(lsh), .value_out(res_lo.re));
  bfp_scaler u_sum_im (.wide_in(w_sum_im), .shift_right(rsh),
    .shift_left(lsh), .value_out(res_lo.im));
  bfp_scaler u_dif_re (.wide_in(w_dif_re), .shift_right(rsh),
    .shift_left(lsh), .value_out(res_hi.re));
  bfp_scaler u_dif_im (.wide_in(w_dif_im), .shift_right(rsh),
    .shift_left(lsh), .value_out(res_hi.im));

  // frame sequencing next values
  always_comb
  begin
    fft_frame_pkg::sample_type s_in;
    s_in = '0;
    next_state = state;
    next_mem = mem;
    next_cnt = cnt;
    next_n_log = n_log;
    next_inv = inv;
    next_err = err;
    next_pass = pass;
    next_bfly = bfly;
    next_mag_or = mag_or;
    next_prev_or = prev_or;
    next_exp_acc = exp_acc;
    next_out_idx = out_idx;
    next_frames = frames;
    next_src_valid = source_valid;
    next_src_sop = source_sop;
    next_src_eop = source_eop;
    next_src_exp = source_exp;
    next_src_data = source_data;
    next_pts_out = fftpts_out;
    // [R3] inverse done by swapping halves around a forward engine
    s_in = (state == fft_frame_pkg::ST_IDLE ? inverse : inv) ?
      {sink_data.im, sink_data.re} : sink_data;
    unique case (state)
      fft_frame_pkg::ST_IDLE:
      begin
        if (take && !sink_sop)
        begin
          // [R5] data without start marker
          next_err = fft_frame_pkg::ERR_MISSING_SOP;
        end
        else if (take)
        begin
          // [R1] length and direction latched on the start sample
          next_n_log = 3'(fft_frame_pkg::MAX_LOG);
          for (int b = 1; b < fft_frame_pkg::PTS_W; b++)
            if (fftpts_in[b])
              next_n_log = 3'(b);
          if (fftpts_in == 4'h1)
            next_n_log = 3'h1;
          next_inv = inverse;
          // [R9] input taken as mantissa with exponent zero
          next_mem[0] = s_in;
          next_mag_or = mag(s_in);
          // [R23] exponent restarts with each frame
          next_exp_acc = 6'sh00;
          // [R24] sample counter restarts at the start marker
          next_cnt = 5'h01;
          next_state = fft_frame_pkg::ST_LOAD;
          // [R7] end marker on the very first sample
          if (sink_eop)
            next_err = fft_frame_pkg::ERR_UNEXPECTED_EOP;
        end
      end
      fft_frame_pkg::ST_LOAD:
      begin
        if (take)
        begin
          next_mem[cnt[3:0]] = s_in;
          next_mag_or = mag_or | mag(s_in);
          next_cnt = cnt + 5'h01;
          if (sink_eop && next_cnt != n_pts)
          begin
            // [R7] end marker too early
            next_err = fft_frame_pkg::ERR_UNEXPECTED_EOP;
            next_state = fft_frame_pkg::ST_IDLE;
          end
          else if (next_cnt == n_pts && !sink_eop)
          begin
            // [R6] frame full but no end marker
            next_err = fft_frame_pkg::ERR_MISSING_EOP;
            next_state = fft_frame_pkg::ST_IDLE;
          end
          else if (next_cnt == n_pts)
          begin
            next_prev_or = next_mag_or;
            next_mag_or = 16'h0000;
            next_pass = 3'h0;
            next_bfly = 3'h0;
            next_state = fft_frame_pkg::ST_PASS;
          end
        end
      end
      fft_frame_pkg::ST_PASS:
      begin
        // [R18] read pair, run engine, write back in place
        next_mem[lo] = res_lo;
        next_mem[hi] = res_hi;
        next_mag_or = mag_or | mag(res_lo) | mag(res_hi);
        next_bfly = bfly + 3'h1;
        if (4'(bfly) == 4'(n_pts[4:1] - 4'h1))
        begin
          // [R11] shifts of this pass join the block total
          next_exp_acc = exp_acc + exp_step;
          // [R12] this pass's maximum steers the next pass
          next_prev_or = next_mag_or;
          next_mag_or = 16'h0000;
          next_bfly = 3'h0;
          next_pass = pass + 3'h1;
          if (next_pass == n_log)
          begin
            next_out_idx = 5'h00;
            next_state = fft_frame_pkg::ST_UNLOAD;
          end
        end
      end
      fft_frame_pkg::ST_UNLOAD:
      begin
        if (!source_valid || source_ready)
        begin
          next_src_valid = 1'b0;
          if (out_idx != n_pts)
          begin
            next_src_valid = 1'b1;
            next_src_sop = (out_idx == 5'h00);
            next_src_eop = (out_idx == n_pts - 5'h01);
            next_src_data = inv ? {mem[out_idx[3:0]].im,
              mem[out_idx[3:0]].re} : mem[out_idx[3:0]];
            // [R15] one shared exponent for every sample of the block
            // [R16] right shifts count negative, left shifts positive
            next_src_exp = exp_acc;
            // [R4] length code rides with each outgoing sample
            next_pts_out = (n_log == 3'(fft_frame_pkg::MAX_LOG)) ?
              4'h0 : 4'(5'h01 << n_log);
            next_out_idx = out_idx + 5'h01;
          end
          else
          begin
            next_frames = frames + 16'h0001;
            next_state = fft_frame_pkg::ST_IDLE;
          end
        end
      end
    endcase
    // input side is open only while idle or loading, enabled and error free
    next_sink_ready = ctrl[fft_frame_pkg::CTRL_ENABLE_BIT] &&
      next_err == fft_frame_pkg::ERR_NONE &&
      (next_state == fft_frame_pkg::ST_IDLE ||
       next_state == fft_frame_pkg::ST_LOAD);
    // [R20] upstream error merged with our own
    next_src_error = next_err | sink_error;
  end

  // frame sequencing registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= fft_frame_pkg::ST_IDLE;
      for (int i = 0; i < fft_frame_pkg::MAX_PTS; i++)
        mem[i] <= '0;
      cnt <= 5'h00;
      n_log <= 3'(fft_frame_pkg::MAX_LOG);
      inv <= 1'b0;
      err <= fft_frame_pkg::ERR_NONE;
      pass <= 3'h0;
      bfly <= 3'h0;
      mag_or <= 16'h0000;
      prev_or <= 16'h0000;
      exp_acc <= fft_frame_pkg::EXP_RESET;
      out_idx <= 5'h00;
      frames <= fft_frame_pkg::FRAMES_RESET;
      sink_ready <= 1'b0;
      source_valid <= 1'b0;
      source_sop <= 1'b0;
      source_eop <= 1'b0;
      source_error <= fft_frame_pkg::ERR_NONE;
      source_exp <= fft_frame_pkg::EXP_RESET;
      source_data <= '0;
      fftpts_out <= 4'h0;
    end
    else
    begin
      state <= next_state;
      mem <= next_mem;
      cnt <= next_cnt;
      n_log <= next_n_log;
      inv <= next_inv;
      err <= next_err;
      pass <= next_pass;
      bfly <= next_bfly;
      mag_or <= next_mag_or;
      prev_or <= next_prev_or;
      exp_acc <= next_exp_acc;
      out_idx <= next_out_idx;
      frames <= next_frames;
      sink_ready <= next_sink_ready;
      source_valid <= next_src_valid;
      source_sop <= next_src_sop;
      source_eop <= next_src_eop;
      source_error <= next_src_error;
      source_exp <= next_src_exp;
      source_data <= next_src_data;
      fftpts_out <= next_pts_out;
    end
  end

  // apb decode: answer lands in the access cycle, no wait states
  always_comb
  begin
    next_ctrl = ctrl;
    next_pready = psel & ~penable;
    next_pslverr = 1'b0;
    next_prdata = 32'h00000000;
    if (psel && !penable)
    begin
      unique case (paddr)
        fft_frame_pkg::CTRL_OFF: next_prdata = ctrl;
        fft_frame_pkg::STATUS_OFF:
        begin
          next_prdata[fft_frame_pkg::STAT_ERR_LSB +: 2] = err;
          next_prdata[fft_frame_pkg::STAT_STATE_LSB +: 2] = state;
          next_prdata[fft_frame_pkg::STAT_EXP_LSB +: 6] = exp_acc;
          next_prdata[fft_frame_pkg::STAT_NLOG_LSB +: 3] = n_log;
        end
        fft_frame_pkg::FRAMES_OFF: next_prdata = {16'h0000, frames};
        default: next_pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pready && pwrite &&
        paddr == fft_frame_pkg::CTRL_OFF)
      next_ctrl = {30'h00000000, pwdata[1:0]};
  end

  // apb registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= fft_frame_pkg::CTRL_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule : fft_frame_ctrl

// file: src/fft_frame_pkg.sv
// Purpose: shared constants and types for the framed fft controller
// Assumes: one 125 MHz clock, apb register access, 16-point max frame
// Notes: fftpts code 0 stands for the largest frame length
package fft_frame_pkg;
  // data path sizes
  localparam int DATA_W = 16;
  localparam int WIDE_W = 17;
  localparam int PTS_W = 4;
  localparam int MAX_LOG = 4;
  localparam int MAX_PTS = 16;
  localparam int EXP_W = 6;
  localparam int ERR_W = 2;
  localparam int CNT_W = 5;
  // framing error codes on the output error field
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_MISSING_SOP = 2'h1;
  localparam logic [1:0] ERR_MISSING_EOP = 2'h2;
  localparam logic [1:0] ERR_UNEXPECTED_EOP = 2'h3;
  // apb register map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] FRAMES_OFF = 12'h008;
  // control fields and reset value
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SCALE_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h00000003;
  // status fields
  localparam int STAT_ERR_LSB = 0;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_EXP_LSB = 8;
  localparam int STAT_NLOG_LSB = 16;
  // reset values
  localparam logic [5:0] EXP_RESET = 6'h00;
  localparam logic [15:0] FRAMES_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_PASS = 2'b10,
    ST_UNLOAD = 2'b11
  } frame_state_type;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } sample_type;

  typedef struct packed {
    logic sop;
    logic eop;
    logic [3:0] pts;
    logic inverse;
  } frame_ctl_type;
endpackage : fft_frame_pkg

// file: src/bfp_scaler.sv
// Purpose: shift one widened butterfly result and round it back to 16 bits
// Assumes: left shifts are only asked for when headroom allows them
// Notes: right shift is applied before rounding so few lsbs are lost
`timescale 1ns/100ps
module bfp_scaler (
  // widened value in
  input wire logic signed [16:0] wide_in,
  // scaling request
  input wire logic shift_right,
  input wire logic [3:0] shift_left,
  // scaled value out
  output logic signed [15:0] value_out
);
  logic signed [17:0] rounded;
  logic signed [17:0] lifted;

  // scale first, then round half up and saturate the rare corner
  always_comb
  begin
    rounded = (18'(wide_in) + 18'sh00001) >>> 1;
    lifted = 18'(wide_in) <<< shift_left;
    if (shift_right)
    begin
      if (rounded > 18'sh07FFF)
        value_out = 16'sh7FFF;
      else
        value_out = rounded[15:0];
    end
    else
    begin
      value_out = lifted[15:0];
    end
  end
endmodule : bfp_scaler

// file: verification/fft_frame_ctrl_props.sv
// Purpose: timing relations on the stream ports of the frame controller
// Assumes: one clock; sink_error stays zero around framing faults
// Notes: helpers mirror the accepted-beat count of the current frame
`timescale 1ns/100ps
module fft_frame_ctrl_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sample stream in
  input wire logic sink_valid,
  input wire logic sink_sop,
  input wire logic sink_eop,
  input wire logic [1:0] sink_error,
  input wire logic [3:0] fftpts_in,
  input wire logic sink_ready,
  // sample stream out
  input wire logic source_ready,
  input wire logic source_valid,
  input wire logic source_sop,
  input wire logic source_eop,
  input wire logic [1:0] source_error,
  input wire logic [5:0] source_exp,
  input wire logic [3:0] fftpts_out
);
  logic [4:0] in_cnt, next_in_cnt, len, next_len, cur_len, nc;
  logic [4:0] out_cnt, next_out_cnt;
  logic in_frame, next_in_frame, acc, live, take;

  // length code to points; odd low codes count as two
  function automatic logic [4:0] pts_len(input logic [3:0] p);
    if (p == 4'h0)
      return 5'h10;
    if (p[3])
      return 5'h08;
    if (p[2])
      return 5'h04;
    return 5'h02;
  endfunction : pts_len

  // a start marker inside a frame is plain data, so it does not restart
  always_comb
  begin
    acc = sink_valid && sink_ready;
    live = in_frame || sink_sop;
    cur_len = in_frame ? len : pts_len(fftpts_in);
    nc = in_frame ? in_cnt + 5'h01 : 5'h01;
    take = source_valid && source_ready;
    next_in_cnt = in_cnt;
    next_len = len;
    next_in_frame = in_frame;
    if (acc && live)
    begin
      next_in_cnt = nc;
      next_len = cur_len;
      next_in_frame = (nc != cur_len);
    end
    next_out_cnt = out_cnt;
    if (take)
      next_out_cnt = source_eop ? 5'h00 : out_cnt + 5'h01;
  end

  // helper registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_cnt <= 5'h00;
      len <= 5'h00;
      in_frame <= 1'b0;
      out_cnt <= 5'h00;
    end
    else
    begin
      in_cnt <= next_in_cnt;
      len <= next_len;
      in_frame <= next_in_frame;
      out_cnt <= next_out_cnt;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_sop_missing: assert property (acc && !live |-> ##[1:3]
    source_error[0]) else $error("beat without start not flagged");
  chk_eop_early: assert property (acc && live && sink_eop &&
    nc < cur_len |-> ##[1:3]
    source_error == fft_frame_pkg::ERR_UNEXPECTED_EOP)
    else $error("early end marker not flagged");
  chk_eop_missing: assert property (acc && live && !sink_eop &&
    nc == cur_len |-> ##[1:3]
    source_error == fft_frame_pkg::ERR_MISSING_EOP)
    else $error("missing end marker not flagged");
  chk_ready_drop: assert property (acc && live &&
    nc == cur_len |=> !sink_ready)
    else $error("ready still high after last beat");
  chk_err_or: assert property (|sink_error |=>
    (source_error & $past(sink_error)) == $past(sink_error))
    else $error("upstream error not passed on");
  chk_exp_shared: assert property ($past(source_valid) &&
    source_valid && !source_sop |-> $stable(source_exp) &&
    $stable(fftpts_out)) else $error("exponent changed inside block");
  chk_frame_beats: assert property (take && source_eop |->
    out_cnt + 5'h01 == pts_len(fftpts_out))
    else $error("output beat count differs from length");
  chk_len_read: assert property (take && source_sop |->
    pts_len(fftpts_out) == len)
    else $error("output length differs from start length");
endmodule : fft_frame_ctrl_props

// file: verification/stream_sink_model.sv
// Purpose: downstream sink that stalls and records each output block
// Assumes: beats move on the valid and ready handshake at pclk
// Notes: slow mode refuses one cycle in three to exercise beat hold
`timescale 1ns/100ps
module stream_sink_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // stream from the block
  input wire logic source_valid,
  input wire logic source_sop,
  input wire logic source_eop,
  input wire logic [5:0] source_exp,
  input wire logic [3:0] fftpts_out,
  input wire fft_frame_pkg::sample_type source_data,
  // pace control and ready
  input wire logic stall_en,
  output logic source_ready
);
  fft_frame_pkg::sample_type beat [16];
  logic [4:0] beat_count;
  logic [5:0] exp_seen;
  logic [3:0] pts_seen;
  logic [7:0] frames_done;
  logic [1:0] phase;

  // ready pattern from a free phase counter
  always_comb
    source_ready = !stall_en || (phase != 2'h2);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 2'h0;
      beat_count <= 5'h00;
      exp_seen <= 6'h00;
      pts_seen <= 4'h0;
      frames_done <= 8'h00;
    end
    else
    begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      if (source_valid && source_ready)
      begin
        beat[source_sop ? 4'h0 : beat_count[3:0]] <= source_data;
        beat_count <= source_sop ? 5'h01 : beat_count + 5'h01;
        exp_seen <= source_exp;
        pts_seen <= fftpts_out;
        frames_done <= frames_done + {7'h00, source_eop};
      end
    end
  end
endmodule : stream_sink_model

// file: verification/fft_frame_ctrl_bench.sv
// Purpose: self-checking bench for the fft frame controller
// Assumes: apb and stream source change just after rising edges
// Notes: scaling is off for exact exponents, on for one frame only
`timescale 1ns/100ps
module fft_frame_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sink_valid, sink_sop, sink_eop, inverse, sink_ready;
  logic source_ready, source_valid, source_sop, source_eop, stall_en;
  logic [1:0] sink_error, source_error;
  logic [5:0] source_exp;
  logic [3:0] fftpts_in, fftpts_out;
  logic [7:0] nf;
  fft_frame_pkg::sample_type sink_data, source_data;
  fft_frame_pkg::sample_type stim [16];
  int bad_count, cmp_count;

  fft_frame_ctrl fft_frame_ctrl_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sink_valid,
    .sink_sop, .sink_eop, .sink_error, .sink_data, .fftpts_in, .inverse,
    .sink_ready, .source_ready, .source_valid, .source_sop, .source_eop,
    .source_error, .source_exp, .source_data, .fftpts_out);
  stream_sink_model sm (.pclk, .presetn, .source_valid, .source_sop,
    .source_eop, .source_exp, .fftpts_out, .source_data, .stall_en,
    .source_ready);

  // free running clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    nf = 8'h00;
  endtask : do_reset

  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the slave
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // each beat stays up until the edge that takes it
  task automatic send(input int beats, input logic [3:0] pts,
    input logic inv, input logic first_sop, input int eop_at);
    @(posedge pclk);
    for (int i = 0; i < beats; i++)
    begin
      sink_valid <= 1'b1;
      sink_sop <= first_sop && i == 0;
      sink_eop <= (i == eop_at);
      sink_data <= stim[i];
      fftpts_in <= pts;
      inverse <= inv;
      do
        @(posedge pclk);
      while (sink_ready !== 1'b1);
    end
    sink_valid <= 1'b0;
  endtask : send

  task automatic frame(input logic [3:0] pts, input logic inv,
    input int n, input logic [5:0] ex);
    int k;
    send(n, pts, inv, 1'b1, n - 1);
    nf++;
    for (k = 0; k < 2000 && sm.frames_done !== nf; k++)
      @(posedge pclk);
    check("frame done", sm.frames_done, nf);
    check("beats", sm.beat_count, n);
    check("pts out", sm.pts_seen, pts);
    check("exp", sm.exp_seen, ex);
  endtask : frame

  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    wrap_up();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sink_valid, sink_sop, sink_eop, inverse, sink_error} = '0;
    {fftpts_in, sink_data, stall_en} = '0;
    do_reset();
    apb(1'b0, fft_frame_pkg::CTRL_OFF, 32'h0);
    check("ctrl reset", rd, fft_frame_pkg::CTRL_RESET);
    apb(1'b0, 12'hFF0, 32'h0);
    check("unmapped", er, 1'b1);
    // fixed right shift per pass gives exact sums and exponents
    apb(1'b1, fft_frame_pkg::CTRL_OFF, 32'h1);
    stim[0] = '{16'h0100, 16'h0040};
    stim[1] = '{16'h0080, 16'hFFC0};
    for (int v = 0; v < 2; v++)
    begin
      frame(4'h2, v[0], 2, 6'h3F);
      check("sum", sm.beat[0], 32'h00C00000);
      check("diff", sm.beat[1], 32'h00400040);
    end
    for (int i = 0; i < 16; i++)
      stim[i] = '{16'h0010, 16'h0000};
    for (int i = 0; i < 4; i++)
    begin
      stall_en <= i[0];
      frame(i == 3 ? 4'h0 : 4'(2 << i), 1'b0, 2 << i, 6'h3F - 6'(i));
    end
    apb(1'b0, fft_frame_pkg::STATUS_OFF, 32'h0);
    check("status", {rd[18:16], rd[13:8]}, {3'h4, 6'h3C});
    // small input must be scaled up and carry a positive exponent
    apb(1'b1, fft_frame_pkg::CTRL_OFF, fft_frame_pkg::CTRL_RESET);
    send(2, 4'h2, 1'b0, 1'b1, 1);
    repeat (40) @(posedge pclk);
    // headroom of ten sign bits on 0x0010 gives a left shift of nine
    check("scaled", sm.beat[0], 32'h40000000);
    check("exp up", sm.exp_seen, 6'h09);
    check("left", {sm.exp_seen[5], |sm.exp_seen}, 2'b01);
    @(posedge pclk);
    sink_error <= 2'h2;
    @(posedge pclk);
    sink_error <= 2'h0;
    @(negedge pclk);
    check("err or", source_error, 2'h2);
    for (int i = 0; i < 3; i++)
    begin
      do_reset();
      send(i == 0 ? 1 : 2, i == 1 ? 4'h4 : 4'h2, 1'b0, i != 0,
        i == 1 ? 1 : 9);
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      check("error", source_error, i == 0 ? 1 : 4 - i);
      check("refused", sink_ready, 1'b0);
      apb(1'b0, fft_frame_pkg::STATUS_OFF, 32'h0);
      check("status err", rd[1:0], i == 0 ? 1 : 4 - i);
    end
    wrap_up();
  end
endmodule : fft_frame_ctrl_bench

bind fft_frame_ctrl fft_frame_ctrl_props fft_frame_ctrl_props_i (.pclk,
  .presetn, .sink_valid, .sink_sop, .sink_eop, .sink_error, .fftpts_in,
  .sink_ready, .source_ready, .source_valid, .source_sop, .source_eop,
  .source_error, .source_exp, .fftpts_out);
